// [src/fwbb_pkg.sv]
// Shared constants, types and helpers for the fast-write target.
// Assumes a 64-bit write beat per bus clock, captured by the data strobes
// outside this logic.
package fwbb_pkg;

	localparam int              ADDR_W    = 32;
	localparam int              DATA_W    = 64;
	localparam int              BE_W      = 8;
	localparam int              BUF_DEPTH = 8;
	localparam int              IDX_W     = 3;
	localparam int              PTR_W     = 4;

	// Data clocks per block; throttle points fall on block boundaries.
	localparam logic [PTR_W-1:0] BLOCK_CLKS   = 4'h4;
	// One short transaction plus a fast back-to-back block.
	localparam logic [PTR_W-1:0] MIN_BUF_CLKS = 4'h5;
	localparam logic [PTR_W-1:0] BUF_SIZE     = 4'h8;
	localparam logic [PTR_W-1:0] PTR_ONE      = 4'h1;
	localparam logic [1:0]       BLK_LAST     = 2'h3;
	localparam logic [1:0]       BLK_STEP     = 2'h1;
	// Bus clocks from the address phase until the decode is trusted.
	localparam logic [1:0]       DEC_CLKS     = 2'h2;
	localparam logic [1:0]       DEC_STEP     = 2'h1;
	localparam logic [ADDR_W-1:0] BEAT_BYTES  = 32'h0000_0008;
	localparam logic [ADDR_W-1:0] FUNC_MASK   = 32'hFFF0_0000;

	localparam logic [3:0]      CMD_MEM_WRITE     = 4'h7;
	localparam logic [3:0]      CMD_MEM_WRITE_INV = 4'hF;

	localparam logic            PIN_N_RST  = 1'b1;
	localparam logic            FLAG_RST   = 1'b0;
	localparam logic [1:0]      CNT_RST    = 2'h0;
	localparam logic [PTR_W-1:0] PTR_RST   = 4'h0;

	typedef enum logic [3:0] {
		FWBB_IDLE    = 4'b0001,
		FWBB_DATA    = 4'b0010,
		FWBB_STOP    = 4'b0100,
		FWBB_FOREIGN = 4'b1000
	} fwbb_state_t;

	typedef struct packed {
		logic              func;
		logic              last;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
		logic [BE_W-1:0]   be_n;
	} fwbb_beat_t;

	localparam fwbb_beat_t BEAT_RST = '0;

	function automatic logic [PTR_W-1:0] fwbb_to_gray(input logic [PTR_W-1:0] b);
		fwbb_to_gray = b ^ (b >> 1);
	endfunction

	function automatic logic [PTR_W-1:0] fwbb_from_gray(input logic [PTR_W-1:0] g);
		logic [PTR_W-1:0] b;
		b = '0;
		b[PTR_W-1] = g[PTR_W-1];
		for (int i = PTR_W - 2; i >= 0; i--) begin
			b[i] = b[i+1] ^ g[i];
		end
		fwbb_from_gray = b;
	endfunction

endpackage

// [src/fwbb_target.sv]
// Fast-write target side of the graphics agent on the expansion port.
// Assumes the core logic is the write initiator and that the bus pins are
// synchronous to i_lnk_clk; accepted writes are handed to i_clk logic.
// Function
// RULE1 - fast write after fast write needs no gap
// RULE2 - fast write then core read needs no gap
// RULE3 - core read then fast write needs turnaround
// RULE4 - fast write then port transfer needs turnaround
// RULE5 - pairing with graphics-initiated cycles needs turnaround
// RULE6 - one dead clock permits a master change
// RULE7 - accept fast back-to-back fast writes
// RULE8 - back-to-back without gap only same master
// RULE9 - assert buffer full when writes cannot fit
// RULE10 - initiator waits while buffer full asserted
// RULE11 - no plain memory writes in fast-write mode
// RULE12 - assert buffer full earlier before fast back-to-back
// RULE13 - buffer at least five clocks of data
// RULE14 - always accept the first four data clocks
// RULE15 - never signal retry on a fast write
// RULE16 - two-clock write finishes without a throttle point
// RULE17 - device select no later than ready or stop
// RULE18 - latch before decode, discard when not addressed
// RULE19 - unselected function drops data, no device select
// RULE20 - hold stop until frame high, then float
// RULE21 - initiator gates frame on sampled buffer full
`timescale 1ns/1ps
module fwbb_target #(
	parameter logic [fwbb_pkg::ADDR_W-1:0] FUNC0_BASE = 32'h1000_0000,
	parameter logic [fwbb_pkg::ADDR_W-1:0] FUNC1_BASE = 32'h2000_0000
) (
	input  wire logic                        i_clk,
	input  wire logic                        i_rst,
	input  wire logic                        i_lnk_clk,
	input  wire logic                        i_frame_n,
	input  wire logic                        i_irdy_n,
	input  wire logic [3:0]                  i_cbe_n,
	input  wire logic [fwbb_pkg::ADDR_W-1:0] i_ad,
	input  wire logic [fwbb_pkg::DATA_W-1:0] i_wdata,
	input  wire logic [fwbb_pkg::BE_W-1:0]   i_wbe_n,
	output logic                             o_devsel_n,
	output logic                             o_devsel_oe_n,
	output logic                             o_trdy_n,
	output logic                             o_trdy_oe_n,
	output logic                             o_stop_n,
	output logic                             o_stop_oe_n,
	output logic                             o_write_buffer_full_n,
	input  wire logic                        i_wr_ready,
	output logic                             o_wr_valid,
	output fwbb_pkg::fwbb_beat_t             o_wr_beat
);
	import fwbb_pkg::*;

	function automatic logic [1:0] fwbb_decode(input logic [ADDR_W-1:0] a);
		fwbb_decode[0] = (a & FUNC_MASK) == FUNC0_BASE;
		fwbb_decode[1] = (a & FUNC_MASK) == FUNC1_BASE;
	endfunction

	// A shared pin is driven high for one clock after release, then floated.
	function automatic logic fwbb_float_n(input logic nx, input logic cur);
		fwbb_float_n = !(nx | cur);
	endfunction

	logic              rst_s1_reg;
	logic              lnk_rst_reg;
	fwbb_state_t       state_reg;
	fwbb_state_t       state_next;
	logic [ADDR_W-1:0] addr_reg;
	logic [ADDR_W-1:0] addr_next;
	logic [1:0]        blk_cnt_reg;
	logic [1:0]        blk_cnt_next;
	logic [1:0]        dec_cnt_reg;
	logic [1:0]        dec_cnt_next;
	logic              first_blk_reg;
	logic              first_blk_next;
	logic              devsel_reg;
	logic              trdy_reg;
	logic              stop_reg;
	logic              full_reg;
	logic              devsel_oe_n_reg;
	logic              trdy_oe_n_reg;
	logic              stop_oe_n_reg;
	logic [PTR_W-1:0]  buf_free;
	fwbb_beat_t        wr_beat;
	logic              rd_valid;
	fwbb_beat_t        rd_beat;
	logic              out_valid_reg;
	fwbb_beat_t        out_beat_reg;

	// The link side leaves reset two bus clocks after the system reset.
	always_ff @(posedge i_lnk_clk) begin
		rst_s1_reg  <= i_rst;
		lnk_rst_reg <= rst_s1_reg;
	end

	wire       in_idle     = state_reg == FWBB_IDLE;
	wire       in_data     = state_reg == FWBB_DATA;
	wire       in_stop     = state_reg == FWBB_STOP;
	wire       in_foreign  = state_reg == FWBB_FOREIGN;

	// Only memory writes are taken; other commands belong to other logic.
	wire       fw_cmd      = (i_cbe_n == CMD_MEM_WRITE) | (i_cbe_n == CMD_MEM_WRITE_INV); // RULE11
	wire       addr_phase  = in_idle & !i_frame_n & fw_cmd; // RULE1 RULE7
	wire       other_start = in_idle & !i_frame_n & !fw_cmd;
	wire [1:0] func_hit    = fwbb_decode(addr_reg);
	wire       hit         = |func_hit;
	wire       dec_done    = dec_cnt_reg == DEC_CLKS;

	// The first block is latched before the decode is known.
	wire       data_valid  = in_data & !i_irdy_n;
	wire       blk_ok      = first_blk_reg | trdy_reg; // RULE14 RULE18
	wire       beat_ok     = data_valid & blk_ok & (buf_free != PTR_RST);
	wire       last_beat   = data_valid & i_frame_n; // RULE16
	wire       at_tp       = beat_ok & (blk_cnt_reg == BLK_LAST) & !i_frame_n;
	wire       room_next   = buf_free > BLOCK_CLKS;
	wire       go_on       = at_tp & hit & room_next;

	// Stop is only raised at a throttle point, after a full block was taken,
	// so a retry (stop with no data) can never appear.
	wire       do_stop     = at_tp & hit & !room_next; // RULE15
	wire       commit      = (last_beat & hit) | do_stop;
	wire       rewind      = last_beat & !hit; // RULE18 RULE19

	// One spare clock is reserved while a transaction runs, since the next one
	// may start back to back before the master can see this flag.
	// Room is counted after this clock's beat and the larger need starts at the
	// address phase, so a one-beat write cannot let a back-to-back one overrun.
	wire [PTR_W-1:0] need  = (in_idle & !addr_phase) ? BLOCK_CLKS : MIN_BUF_CLKS; // RULE12 RULE13
	wire [PTR_W-1:0] free_after = buf_free - {{(PTR_W-1){1'b0}}, beat_ok};
	wire       full_next   = free_after < need; // RULE9 RULE10 RULE21

	wire       trdy_next   = in_data & (at_tp ? go_on : (trdy_reg & !last_beat));
	wire       stop_next   = do_stop | (stop_reg & !i_frame_n); // RULE20
	wire       claim       = ((in_data & !last_beat) | (in_stop & !i_frame_n)) & hit & dec_done;
	wire       devsel_next = claim | trdy_next | stop_next; // RULE17

	assign wr_beat.func  = func_hit[1];
	assign wr_beat.last  = i_frame_n | do_stop;
	assign wr_beat.addr  = addr_reg;
	assign wr_beat.data  = i_wdata;
	assign wr_beat.be_n  = i_wbe_n;

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			FWBB_IDLE: begin
				if (addr_phase) begin
					state_next = FWBB_DATA;
				end else if (other_start) begin
					state_next = FWBB_FOREIGN;
				end
			end
			FWBB_DATA: begin
				if (last_beat) begin
					state_next = FWBB_IDLE;
				end else if (do_stop) begin
					state_next = FWBB_STOP;
				end
			end
			FWBB_STOP: begin
				if (i_frame_n) begin
					state_next = FWBB_IDLE;
				end
			end
			FWBB_FOREIGN: begin
				if (i_frame_n & i_irdy_n) begin // RULE3 RULE5
					state_next = FWBB_IDLE;
				end
			end
			default: begin
				state_next = FWBB_IDLE;
			end
		endcase
	end

	always_comb begin
		addr_next      = addr_reg;
		blk_cnt_next   = blk_cnt_reg;
		dec_cnt_next   = dec_cnt_reg;
		first_blk_next = first_blk_reg;
		if (addr_phase) begin
			addr_next      = i_ad;
			blk_cnt_next   = CNT_RST;
			dec_cnt_next   = CNT_RST;
			first_blk_next = 1'b1;
		end else begin
			if (beat_ok) begin
				addr_next    = addr_reg + BEAT_BYTES;
				blk_cnt_next = blk_cnt_reg + BLK_STEP;
			end
			if (beat_ok & (blk_cnt_reg == BLK_LAST)) begin
				first_blk_next = 1'b0;
			end
			if (!in_idle & !dec_done) begin
				dec_cnt_next = dec_cnt_reg + DEC_STEP;
			end
		end
	end

	always_ff @(posedge i_lnk_clk) begin
		if (lnk_rst_reg) begin
			state_reg     <= FWBB_IDLE;
			addr_reg      <= '0;
			blk_cnt_reg   <= CNT_RST;
			dec_cnt_reg   <= CNT_RST;
			first_blk_reg <= FLAG_RST;
		end else begin
			state_reg     <= state_next;
			addr_reg      <= addr_next;
			blk_cnt_reg   <= blk_cnt_next;
			dec_cnt_reg   <= dec_cnt_next;
			first_blk_reg <= first_blk_next;
		end
	end

	always_ff @(posedge i_lnk_clk) begin
		if (lnk_rst_reg) begin
			devsel_reg      <= FLAG_RST;
			trdy_reg        <= FLAG_RST;
			stop_reg        <= FLAG_RST;
			full_reg        <= FLAG_RST;
			devsel_oe_n_reg <= PIN_N_RST;
			trdy_oe_n_reg   <= PIN_N_RST;
			stop_oe_n_reg   <= PIN_N_RST;
		end else begin
			devsel_reg      <= devsel_next;
			trdy_reg        <= trdy_next;
			stop_reg        <= stop_next;
			full_reg        <= full_next;
			devsel_oe_n_reg <= fwbb_float_n(devsel_next, devsel_reg);
			trdy_oe_n_reg   <= fwbb_float_n(trdy_next, trdy_reg);
			stop_oe_n_reg   <= fwbb_float_n(stop_next, stop_reg); // RULE20
		end
	end

	assign o_devsel_n            = !devsel_reg;
	assign o_trdy_n              = !trdy_reg;
	assign o_stop_n              = !stop_reg;
	assign o_write_buffer_full_n = !full_reg;
	assign o_devsel_oe_n         = devsel_oe_n_reg;
	assign o_trdy_oe_n           = trdy_oe_n_reg;
	assign o_stop_oe_n           = stop_oe_n_reg;

	// The output stage refills whenever it is empty or being drained, so a
	// stalled consumer backs up into the buffer and then into the full flag.
	wire rd_load = rd_valid & (!out_valid_reg | i_wr_ready);

	fwbb_xfer u_xfer (
		.i_wclk     (i_lnk_clk),
		.i_wrst     (lnk_rst_reg),
		.i_wr_en    (beat_ok),
		.i_wr_beat  (wr_beat),
		.i_commit   (commit),
		.i_rewind   (rewind),
		.o_free     (buf_free),
		.i_rclk     (i_clk),
		.i_rrst     (i_rst),
		.i_rd_en    (rd_load),
		.o_rd_valid (rd_valid),
		.o_rd_beat  (rd_beat)
	);

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			out_valid_reg <= FLAG_RST;
			out_beat_reg  <= BEAT_RST;
		end else begin
			if (rd_load) begin
				out_beat_reg <= rd_beat;
			end
			out_valid_reg <= rd_load | (out_valid_reg & !i_wr_ready);
		end
	end

	assign o_wr_valid = out_valid_reg;
	assign o_wr_beat  = out_beat_reg;

	sequence s_last_beat;
		in_data && !i_irdy_n && i_frame_n;
	endsequence

	sequence s_next_addr;
		!i_frame_n && fw_cmd;
	endsequence

	sequence s_short_write;
		addr_phase ##1 (!i_irdy_n && i_frame_n);
	endsequence

	AST_FBB_TAKEN: assert property (@(posedge i_lnk_clk) disable iff (lnk_rst_reg) // RULE7
		s_last_beat ##1 s_next_addr |=> in_data && first_blk_reg)
		else $error("Back-to-back fast write was not taken.");

	AST_FIRST_BLOCK: assert property (@(posedge i_lnk_clk) disable iff (lnk_rst_reg) // RULE14
		(in_data && first_blk_reg && !i_irdy_n && buf_free != PTR_RST) |=> addr_reg == $past(addr_reg) + BEAT_BYTES)
		else $error("A first-block data clock was not latched.");

	AST_NO_RETRY: assert property (@(posedge i_lnk_clk) disable iff (lnk_rst_reg) // RULE15
		$fell(o_stop_n) |-> $past(beat_ok) && $past(blk_cnt_reg) == BLK_LAST)
		else $error("Stop raised without a whole block taken.");

	AST_DEVSEL_LEAD: assert property (@(posedge i_lnk_clk) disable iff (lnk_rst_reg) // RULE17
		(!o_trdy_n || !o_stop_n) |-> !o_devsel_n && !o_devsel_oe_n)
		else $error("Ready or stop driven without device select.");

	AST_SHORT_WRITE: assert property (@(posedge i_lnk_clk) disable iff (lnk_rst_reg) // RULE16
		s_short_write |=> in_idle && o_trdy_n && o_stop_n)
		else $error("Two-clock write did not finish cleanly.");

	AST_MISS_QUIET: assert property (@(posedge i_lnk_clk) disable iff (lnk_rst_reg) // RULE19
		(in_data && !hit) |=> o_devsel_n && o_trdy_n)
		else $error("Unaddressed function claimed the transaction.");

	AST_STOP_HOLD: assert property (@(posedge i_lnk_clk) disable iff (lnk_rst_reg) // RULE20
		(!o_stop_n && !i_frame_n) |=> !o_stop_n)
		else $error("Stop released before frame was seen high.");

	AST_STOP_FLOAT: assert property (@(posedge i_lnk_clk) disable iff (lnk_rst_reg) // RULE20
		(!o_stop_n && i_frame_n) |=> o_stop_n && !o_stop_oe_n ##1 o_stop_oe_n)
		else $error("Stop was not released and floated.");

	AST_FULL_IDLE: assert property (@(posedge i_lnk_clk) disable iff (lnk_rst_reg) // RULE9
		(in_idle && buf_free < BLOCK_CLKS) |=> !o_write_buffer_full_n)
		else $error("Buffer full not flagged with no room for a block.");

	AST_FULL_EARLY: assert property (@(posedge i_lnk_clk) disable iff (lnk_rst_reg) // RULE12
		(s_last_beat and (buf_free < MIN_BUF_CLKS)) |=> !o_write_buffer_full_n)
		else $error("Buffer full not flagged ahead of a back-to-back write.");

endmodule

// [src/fwbb_xfer.sv]
// Write buffer between the bus clock and the system clock.
// Assumes the writer commits or rewinds each transaction once it ends.
`timescale 1ns/1ps
module fwbb_xfer (
	input  wire logic                       i_wclk,
	input  wire logic                       i_wrst,
	input  wire logic                       i_wr_en,
	input  wire fwbb_pkg::fwbb_beat_t       i_wr_beat,
	input  wire logic                       i_commit,
	input  wire logic                       i_rewind,
	output logic [fwbb_pkg::PTR_W-1:0]      o_free,
	input  wire logic                       i_rclk,
	input  wire logic                       i_rrst,
	input  wire logic                       i_rd_en,
	output logic                            o_rd_valid,
	output fwbb_pkg::fwbb_beat_t            o_rd_beat
);
	import fwbb_pkg::*;

	fwbb_beat_t       mem [BUF_DEPTH];
	logic [PTR_W-1:0] spec_reg;
	logic [PTR_W-1:0] cmt_reg;
	logic [PTR_W-1:0] cmt_gray_reg;
	logic [PTR_W-1:0] rgray_s1_reg;
	logic [PTR_W-1:0] rgray_s2_reg;
	logic [PTR_W-1:0] rd_reg;
	logic [PTR_W-1:0] rd_gray_reg;
	logic [PTR_W-1:0] cgray_s1_reg;
	logic [PTR_W-1:0] cgray_s2_reg;
	logic [PTR_W-1:0] pub_reg;

	// Only committed beats are visible to the reader; speculative beats of an
	// undecoded transaction can be dropped by moving the write pointer back.
	wire  [PTR_W-1:0] rd_seen  = fwbb_from_gray(rgray_s2_reg);
	wire  [PTR_W-1:0] used     = spec_reg - rd_seen;
	wire              wr_go    = i_wr_en & (o_free != PTR_RST) & !i_rewind;
	wire  [PTR_W-1:0] spec_inc = spec_reg + PTR_ONE;
	wire  [PTR_W-1:0] spec_nx  = i_rewind ? cmt_reg : (wr_go ? spec_inc : spec_reg);
	wire  [PTR_W-1:0] cmt_nx   = i_commit & !i_rewind ? spec_nx : cmt_reg;
	wire  [PTR_W-1:0] cmt_seen = fwbb_from_gray(cgray_s2_reg);
	// The reader sees the committed count move one step per clock, so the gray
	// word never changes in more than one bit even when a whole burst commits.
	wire  [PTR_W-1:0] pub_nx   = (pub_reg != cmt_reg) ? pub_reg + PTR_ONE : pub_reg;
	wire              rd_go    = i_rd_en & o_rd_valid;

	assign o_free     = BUF_SIZE - used;
	assign o_rd_valid = rd_reg != cmt_seen;
	assign o_rd_beat  = mem[rd_reg[IDX_W-1:0]];

	always_ff @(posedge i_wclk) begin
		if (wr_go) begin
			mem[spec_reg[IDX_W-1:0]] <= i_wr_beat;
		end
	end

	always_ff @(posedge i_wclk) begin
		if (i_wrst) begin
			spec_reg     <= PTR_RST;
			cmt_reg      <= PTR_RST;
			pub_reg      <= PTR_RST;
			cmt_gray_reg <= PTR_RST;
			rgray_s1_reg <= PTR_RST;
			rgray_s2_reg <= PTR_RST;
		end else begin
			spec_reg     <= spec_nx;
			cmt_reg      <= cmt_nx;
			pub_reg      <= pub_nx;
			cmt_gray_reg <= fwbb_to_gray(pub_nx);
			rgray_s1_reg <= rd_gray_reg;
			rgray_s2_reg <= rgray_s1_reg;
		end
	end

	always_ff @(posedge i_rclk) begin
		if (i_rrst) begin
			rd_reg       <= PTR_RST;
			rd_gray_reg  <= PTR_RST;
			cgray_s1_reg <= PTR_RST;
			cgray_s2_reg <= PTR_RST;
		end else begin
			rd_reg       <= rd_go ? rd_reg + PTR_ONE : rd_reg;
			rd_gray_reg  <= fwbb_to_gray(rd_go ? rd_reg + PTR_ONE : rd_reg);
			cgray_s1_reg <= cmt_gray_reg;
			cgray_s2_reg <= cgray_s1_reg;
		end
	end

	AST_DISCARD: assert property (@(posedge i_wclk) disable iff (i_wrst) // RULE18
		i_rewind |=> (spec_reg == $past(cmt_reg)) && $stable(cmt_reg))
		else $error("Rewound beats were not discarded.");

	AST_COMMIT: assert property (@(posedge i_wclk) disable iff (i_wrst) // RULE19
		(i_commit && !i_rewind) |=> cmt_reg == spec_reg)
		else $error("Committed pointer did not follow the written beats.");

endmodule

// [verif/fast_write_back_to_back_seq_test.sv]
// Self-checking bench for the fast-write target with an initiator model.
// Assumes the system side consumes beats through a valid/ready pair.
`timescale 1ns/1ps
module fast_write_back_to_back_seq_test;
	import fwbb_pkg::*;
	localparam logic [31:0] F0 = 32'h1000_0000;
	localparam logic [31:0] F1 = 32'h2000_0000;
	logic       i_clk      = 1'b0;
	logic       i_lnk_clk  = 1'b0;
	logic       i_rst      = 1'b1;
	logic       i_wr_ready = 1'b0;
	logic       frame_n;
	logic       irdy_n;
	logic [3:0] cbe_n;
	logic [31:0] ad;
	logic [63:0] wdata;
	logic [7:0] wbe_n;
	logic       o_devsel_n;
	logic       o_devsel_oe_n;
	logic       o_trdy_n;
	logic       o_trdy_oe_n;
	logic       o_stop_n;
	logic       o_stop_oe_n;
	logic       o_write_buffer_full_n;
	logic       o_wr_valid;
	fwbb_beat_t o_wr_beat;
	fwbb_beat_t exp_b;
	int         failures = 0;
	int         n_tests = 0;
	int         rdy_mode = 0;
	int         devsel_seen = 0;
	logic       prev_stop = 1'b1;
	logic       prev_frame = 1'b1;
	wire logic  devsel_w = o_devsel_oe_n ? 1'b1 : o_devsel_n;
	wire logic  trdy_w = o_trdy_oe_n ? 1'b1 : o_trdy_n;
	wire logic  stop_w = o_stop_oe_n ? 1'b1 : o_stop_n;

	fwbb_target #(.FUNC0_BASE(F0), .FUNC1_BASE(F1)) i_fwbb_target (
		.i_clk(i_clk), .i_rst(i_rst), .i_lnk_clk(i_lnk_clk),
		.i_frame_n(frame_n), .i_irdy_n(irdy_n), .i_cbe_n(cbe_n), .i_ad(ad),
		.i_wdata(wdata), .i_wbe_n(wbe_n),
		.o_devsel_n(o_devsel_n), .o_devsel_oe_n(o_devsel_oe_n),
		.o_trdy_n(o_trdy_n), .o_trdy_oe_n(o_trdy_oe_n),
		.o_stop_n(o_stop_n), .o_stop_oe_n(o_stop_oe_n),
		.o_write_buffer_full_n(o_write_buffer_full_n),
		.i_wr_ready(i_wr_ready), .o_wr_valid(o_wr_valid), .o_wr_beat(o_wr_beat)
	);

	fwbb_init #(.F0_BASE(F0), .F1_BASE(F1)) i_fwbb_init (
		.i_lnk_clk(i_lnk_clk), .i_devsel_n(devsel_w), .i_trdy_n(trdy_w),
		.i_stop_n(stop_w), .i_write_buffer_full_n(o_write_buffer_full_n),
		.o_frame_n(frame_n), .o_irdy_n(irdy_n), .o_cbe_n(cbe_n), .o_ad(ad),
		.o_wdata(wdata), .o_wbe_n(wbe_n)
	);

	always #25 i_clk = ~i_clk;

	// The odd start offset keeps the two clocks out of phase.
	initial begin
		#3.3;
		forever #7.5 i_lnk_clk = ~i_lnk_clk;
	end

	always @(posedge i_clk) begin
		i_wr_ready <= (rdy_mode == 0) ? 1'($urandom) : (rdy_mode == 2);
	end

	task automatic check(input logic [127:0] seen, input logic [127:0] exp, input string what);
		n_tests++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
		end
	endtask

	always @(posedge i_clk) begin
		if (!i_rst && o_wr_valid === 1'b1 && i_wr_ready === 1'b1) begin
			exp_b = (i_fwbb_init.exp_q.size() > 0) ? i_fwbb_init.exp_q.pop_front() : '1;
			check(o_wr_beat, exp_b, "beat");
		end
	end

	always @(posedge i_lnk_clk) begin
		if (!i_rst) begin
			if (!trdy_w || !stop_w) check(devsel_w, 1'b0, "devsel");
			if (!stop_w && !frame_n) check(i_fwbb_init.n_acc >= 4, 1'b1, "early stop");
			if (!prev_stop && !prev_frame) check(stop_w, 1'b0, "stop held");
			if (!devsel_w) devsel_seen++;
		end
		prev_stop  <= stop_w;
		prev_frame <= frame_n;
	end

	task automatic done_test(input string name);
		int w;
		i_fwbb_init.idle(3);
		rdy_mode = 0;
		for (w = 0; w < 400 && i_fwbb_init.exp_q.size() > 0; w++) @(posedge i_clk);
		repeat (10) @(posedge i_clk);
		check(i_fwbb_init.exp_q.size(), 0, "undelivered");
		check({o_devsel_oe_n, o_trdy_oe_n, o_stop_oe_n}, 3'b111, "float");
		$display("test %s done", name);
	endtask

	task automatic summarize;
		$display("checks %0d failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	initial begin
		void'($urandom(32'h45F4));
		repeat (8) @(posedge i_clk);
		i_rst <= 1'b0;
		check({o_write_buffer_full_n, o_devsel_oe_n, o_trdy_oe_n, o_stop_oe_n, o_wr_valid}, 5'b11110, "reset");
		repeat (6) @(posedge i_lnk_clk);
		// Short writes, alternating functions and both write commands.
		i_fwbb_init.fw_write(F0 + 32'h40, 1, 1, 4'h7);
		i_fwbb_init.fw_write(F1 + 32'h80, 1, 0, 4'hF);
		i_fwbb_init.fw_write(F0, 2, 0, 4'h7);
		i_fwbb_init.fw_write(F1, 3, 0, 4'hF);
		done_test("short back to back");
		i_fwbb_init.fw_write(F0 + 32'h100, 8, 1, 4'hF);
		check(i_fwbb_init.n_acc, 8, "long accepted");
		done_test("long burst");
		devsel_seen = 0;
		i_fwbb_init.fw_write(32'h3000_0000, 6, 1, 4'h7);
		check(devsel_seen, 0, "miss devsel");
		i_fwbb_init.fw_write(F1 + 32'h100, 2, 0, 4'h7);
		i_fwbb_init.fw_write(F0, 2, 0, 4'h6);
		i_fwbb_init.fw_write(F1 + 32'h40, 1, 1, 4'h7);
		done_test("decode miss");
		rdy_mode = 1;
		i_fwbb_init.fw_write(F0, 4, 1, 4'h7);
		i_fwbb_init.idle(4);
		check(o_write_buffer_full_n, 1'b1, "room left");
		i_fwbb_init.fw_write(F1, 2, 0, 4'h7);
		fork
			i_fwbb_init.fw_write(F0 + 32'h200, 4, 0, 4'hF);
			begin
				repeat (20) @(posedge i_lnk_clk);
				check(o_write_buffer_full_n, 1'b0, "full");
				check(frame_n, 1'b1, "held off");
				rdy_mode = 0;
			end
		join
		done_test("buffer full");
		rdy_mode = 1;
		i_fwbb_init.fw_write(F1 + 32'h400, 12, 1, 4'hF);
		check(i_fwbb_init.stopped, 1'b1, "disconnect");
		check(i_fwbb_init.n_acc, 8, "stop accepted");
		done_test("disconnect");
		summarize();
	end

	initial begin
		#200000;
		failures++;
		summarize();
	end
endmodule

// [verif/fwbb_init.sv]
// Core logic initiator model issuing fast writes on the bus clock.
// Assumes target pins arrive as resolved levels, pulled high when floated.
`timescale 1ns/1ps
module fwbb_init #(
	parameter logic [31:0] F0_BASE = 32'h1000_0000,
	parameter logic [31:0] F1_BASE = 32'h2000_0000
) (
	input  wire logic        i_lnk_clk,
	input  wire logic        i_devsel_n,
	input  wire logic        i_trdy_n,
	input  wire logic        i_stop_n,
	input  wire logic        i_write_buffer_full_n,
	output logic             o_frame_n,
	output logic             o_irdy_n,
	output logic [3:0]       o_cbe_n,
	output logic [31:0]      o_ad,
	output logic [63:0]      o_wdata,
	output logic [7:0]       o_wbe_n
);
	import fwbb_pkg::*;
	fwbb_beat_t exp_q[$];
	int         n_acc;
	logic       stopped;

	initial begin
		o_frame_n = 1'b1;
		o_irdy_n  = 1'b1;
		o_cbe_n   = 4'hF;
		o_ad      = 32'h0;
		o_wdata   = 64'h0;
		o_wbe_n   = 8'hFF;
	end

	// Released lines toggle so a stale value is never mistaken for data.
	task automatic idle(input int n);
		repeat (n) begin
			o_frame_n <= 1'b1;
			o_irdy_n  <= 1'b1;
			o_ad      <= ~o_ad;
			o_wdata   <= ~o_wdata;
			@(posedge i_lnk_clk);
		end
	endtask

	task automatic fw_write(input logic [31:0] a, input int n, input int gap, input logic [3:0] cmd);
		fwbb_beat_t pend[$];
		fwbb_beat_t b;
		logic       hit;
		hit = ((a[31:20] == F0_BASE[31:20]) || (a[31:20] == F1_BASE[31:20])) && (cmd[2:0] == 3'h7);
		idle(gap);
		while (i_write_buffer_full_n !== 1'b1) begin
			idle(1);
		end
		o_frame_n <= 1'b0;
		o_irdy_n  <= 1'b1;
		o_cbe_n   <= cmd;
		o_ad      <= a;
		n_acc     = 0;
		stopped   = 1'b0;
		@(posedge i_lnk_clk);
		for (int k = 0; k < n && !stopped; k++) begin
			b.func = (a[31:20] == F1_BASE[31:20]);
			b.last = 1'b0;
			b.addr = a + 32'(8 * k);
			b.data = {$urandom, $urandom};
			b.be_n = 8'($urandom);
			o_irdy_n  <= 1'b0;
			o_frame_n <= (k == n - 1);
			o_wdata   <= b.data;
			o_wbe_n   <= b.be_n;
			@(posedge i_lnk_clk);
			while (k >= 4 && i_trdy_n && i_stop_n && !i_devsel_n) begin
				@(posedge i_lnk_clk);
			end
			if (k < 4 || !i_trdy_n) begin
				pend.push_back(b);
				n_acc++;
			end
			stopped = !i_stop_n || (k >= 4 && i_devsel_n);
		end
		// A cut transaction still ends with frame high while irdy marks the final phase.
		if (stopped) begin
			o_frame_n <= 1'b1;
			o_irdy_n  <= 1'b0;
			@(posedge i_lnk_clk);
		end
		if (hit && pend.size() > 0) begin
			pend[pend.size() - 1].last = 1'b1;
			exp_q = {exp_q, pend};
		end
	endtask
endmodule
